// ==== src/adc_seq_pkg.sv ====
// Shared constants and types for the converter scan sequencer
package adc_seq_pkg;
	// ==========================================================
	// Widths
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int NCHAN  = 4;
	localparam int DIV_W  = 3;
	// ==========================================================
	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_CHAN   = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_CLKDIV = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_INTEN  = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_LIM_HI = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_LIM_LO = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_RES0   = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_RES3   = 4'hB;
	// ==========================================================
	// Field positions
	localparam int CTRL_EN    = 0;
	localparam int CTRL_MODE  = 1;
	localparam int CTRL_TMR   = 4;
	localparam int CTRL_GO    = 5;
	localparam int CTRL_DAC   = 6;
	localparam int ST_DONE    = 0;
	localparam int ST_BND     = 1;
	localparam int ST_BUSY    = 2;
	localparam int IE_DONE    = 0;
	localparam int IE_BND     = 1;
	localparam int NIB_LO     = 4;
	// ==========================================================
	// Reset values and counts
	localparam logic [DATA_W-1:0] LIM_HI_RST = 8'hFF;
	localparam logic [DATA_W-1:0] LIM_LO_RST = 8'h00;
	localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;
	localparam logic [DATA_W-1:0] MSB_TRIAL  = 8'h80;
	localparam logic [1:0]        LAST_SLOT  = 2'h3;
	localparam logic [2:0]        NIB_BIT    = 3'h4;
	// Operating modes in control field order
	typedef enum logic [2:0] {
		MODE_FIX_SINGLE, MODE_FIX_CONT, MODE_SCAN_SINGLE,
		MODE_SCAN_CONT, MODE_DUAL_CONT, MODE_STEP
	} mode_e;
	// Lowest set channel of a mask, zero when empty
	function automatic logic [1:0] lowest_chan(input logic [3:0] m);
		logic [1:0] r;
		r = 2'h0;
		for (int i = NCHAN - 1; i >= 0; i--)
			if (m[i])
				r = 2'(i);
		return r;
	endfunction
endpackage

// ==== src/adc_core_if.sv ====
// Signals between the sequencer, clock divider and SAR core
`timescale 1ns/100ps
interface adc_core_if;
	logic       tick;      // Converter clock pulse
	logic [2:0] div_sel;   // Divide setting minus one
	logic       start;     // Begin a conversion
	logic       abort;     // Drop any conversion in flight
	logic       comp;      // Comparator: input at or above trial
	logic       dac_load;  // Load DAC value into the code register
	logic [7:0] dac_val;   // Value for DAC output
	logic       busy;      // Conversion in flight
	logic       sampling;  // Sample-and-hold tracking
	logic       nib_valid; // Upper four bits resolved
	logic       done;      // Conversion finished
	logic [7:0] code;      // Trial or DAC code
	modport div (input div_sel, output tick);
	modport sar (input tick, start, abort, comp, dac_load, dac_val,
		output busy, sampling, nib_valid, done, code);
	modport seq (input tick, busy, sampling, nib_valid, done, code,
		output div_sel, start, abort, comp, dac_load, dac_val);
endinterface

// ==== src/adc_clk_div.sv ====
// Programmable converter clock divider, divide by 1 to 8
`timescale 1ns/100ps
module adc_clk_div
	import adc_seq_pkg::*;
(
	input  wire logic clk_in,   // System clock
	input  wire logic reset_in, // Synchronous reset
	adc_core_if.div   core      // Divider side
);
	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W-1:0] cnt_d;
	logic             tick_q;
	logic             tick_d;
	// ==========================================================
	// Count to the setting, then pulse
	always_comb
	begin
		tick_d = (cnt_q >= core.div_sel);
		cnt_d  = tick_d ? '0 : cnt_q + 1'b1;
	end
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end
	assign core.tick = tick_q;
endmodule

// ==== src/adc_sar_core.sv ====
// Successive-approximation register with sample phase
`timescale 1ns/100ps
module adc_sar_core
	import adc_seq_pkg::*;
(
	input  wire logic clk_in,   // System clock
	input  wire logic reset_in, // Synchronous reset
	adc_core_if.sar   core      // SAR side
);
	logic [DATA_W-1:0] code_q, code_d;
	logic [2:0]        bit_q, bit_d;
	logic              busy_q, busy_d, samp_q, samp_d;
	logic              nib_q, nib_d, done_q, done_d;
	// ==========================================================
	// One sample tick, then one bit per tick from the MSB
	always_comb
	begin
		code_d = code_q;
		bit_d  = bit_q;
		busy_d = busy_q;
		samp_d = samp_q;
		nib_d  = 1'b0;
		done_d = 1'b0;
		if (core.abort)
		begin
			busy_d = 1'b0;
			samp_d = 1'b0;
			// A stopped converter still takes a DAC value
			if (core.dac_load)
				code_d = core.dac_val;
		end
		else if (core.start && !busy_q)
		begin
			busy_d = 1'b1;
			samp_d = 1'b1;
			bit_d  = 3'h7;
			code_d = MSB_TRIAL;
		end
		else if (busy_q && core.tick)
		begin
			if (samp_q)
				samp_d = 1'b0;
			else
			begin
				code_d[bit_q] = core.comp;
				if (bit_q != 3'h0)
					code_d[bit_q - 1'b1] = 1'b1;
				nib_d = (bit_q == NIB_BIT);
				done_d = (bit_q == 3'h0);
				busy_d = (bit_q != 3'h0);
				bit_d  = bit_q - 1'b1;
			end
		end
		else if (core.dac_load && !busy_q)
			code_d = core.dac_val;
	end
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			code_q <= ZERO_BYTE;
			bit_q  <= 3'h0;
			busy_q <= 1'b0;
			samp_q <= 1'b0;
			nib_q  <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			code_q <= code_d;
			bit_q  <= bit_d;
			busy_q <= busy_d;
			samp_q <= samp_d;
			nib_q  <= nib_d;
			done_q <= done_d;
		end
	end
	assign core.code      = code_q;
	assign core.busy      = busy_q;
	assign core.sampling  = samp_q;
	assign core.nib_valid = nib_q;
	assign core.done      = done_q;
endmodule

// ==== src/adc_scan_sequencer.sv ====
// Scan sequencer, limit check and registers for a 4-channel 8-bit SAR ADC
// Behaviour
// - Auto-scan single converts each chosen channel once into its own register
// - Auto-scan single flags completion after last channel; one channel acts fixed
// - Auto-scan continuous flags each pass, restarts from lowest chosen channel
// - Fixed and dual continuous modes overwrite the four result registers cyclically, no hold-off
// - Continuous conversion runs until software stops it
// - Dual mode alternates two channels into registers 0,1,2,3 in order
// - Dual mode flags completion after every four conversions
// - Single-step converts one channel, flags, waits for a fresh start
// - Timer zero overflow starts conversion when timer start is selected
// - Timer overflows during a conversion are ignored
// - Immediate start launches a conversion at once in any mode
// - Upper nibble checked against limit nibbles, outside raises boundary
// - If nibble inside, full eight-bit result checked against limits
// - Clearing boundary enable stops all boundary events
// - DAC mode drives result register 3 value onto channel 3 pin
// - Converter clock divider selects divide by 1 to 8
// - Converter runs in Idle; enabled completion wakes the device
// - Power-down stops conversions and all events
// - Fixed single converts one channel once into its register, then flags
// - Fixed continuous fills four registers in turn, flags every four
`timescale 1ns/100ps
module adc_scan_sequencer
	import adc_seq_pkg::*;
(
	input  wire logic                      clk_in,          // 40 MHz clock
	input  wire logic                      reset_in,        // Sync reset
	input  wire logic [adc_seq_pkg::ADDR_W-1:0] addr_in,    // Reg address
	input  wire logic [adc_seq_pkg::DATA_W-1:0] wdata_in,   // Write data
	input  wire logic                      wr_in,           // Write strobe
	input  wire logic                      rd_in,           // Read strobe
	output logic [adc_seq_pkg::DATA_W-1:0] rdata_out,       // Read data
	input  wire logic                      timer_ovf_in,    // Timer 0 pulse
	input  wire logic                      idle_in,         // Idle mode
	input  wire logic                      power_down_in,   // Power-down
	input  wire logic                      comp_in,         // Comparator
	output logic [1:0]                     mux_sel_out,     // Input mux
	output logic                           sample_out,      // Sample-hold
	output logic [adc_seq_pkg::DATA_W-1:0] dac_code_out,    // DAC code
	output logic                           dac_pin_en_out,  // DAC to pin 3
	output logic                           irq_out,         // Interrupt
	output logic                           wake_out         // Idle wakeup
);
	// ==========================================================
	// Core connections
	adc_core_if core ();

	adc_clk_div u_div
	(
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.core     (core)
	);

	adc_sar_core u_sar
	(
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.core     (core)
	);

	typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_WAIT} seq_st_e;

	// Register file state
	logic                   en_q, en_d, tmr_q, tmr_d, dac_q, dac_d;
	logic [2:0]             mode_q, mode_d;
	logic [NCHAN-1:0]       mask_q, mask_d;
	logic [DIV_W-1:0]       div_q, div_d;
	logic                   die_q, die_d, bie_q, bie_d;
	logic                   fdone_q, fdone_d, fbnd_q, fbnd_d;
	logic [DATA_W-1:0]      lim_hi_q, lim_hi_d, lim_lo_q, lim_lo_d;
	logic [DATA_W-1:0]      rdata_q, rdata_d;
	logic                   irq_q, irq_d, wake_q, wake_d;
	logic [DATA_W-1:0]      res_q [NCHAN];
	logic [DATA_W-1:0]      res_d [NCHAN];
	// Sequencer state
	seq_st_e                st_q, st_d;
	logic [1:0]             chan_q, chan_d, slot_q, slot_d;
	logic [NCHAN-1:0]       pend_q, pend_d;
	logic                   early_q, early_d, start_q, start_d;
	// Sequencer events toward the register file
	logic                   res_we, set_done, set_bnd, go, imm_go;
	logic [1:0]             res_idx;
	mode_e                  mode, go_mode;
	logic [1:0]             chan_b;
	logic                   out4, out8, stop;

	assign mode = mode_e'(mode_q);

	// ==========================================================
	// Start and stop conditions
	always_comb
	begin
		imm_go = wr_in && addr_in == OFS_CTRL && wdata_in[CTRL_GO]
			&& wdata_in[CTRL_EN];
		// A start write carries its own mode and enable
		go_mode = imm_go ? mode_e'(wdata_in[CTRL_MODE +: 3]) : mode;
		stop = (!en_q && !imm_go) || power_down_in;
		// Overflow counts only when selected and not converting
		go = !power_down_in && (imm_go
			|| (en_q && tmr_q && timer_ovf_in));
		chan_b = lowest_chan(mask_q & ~(4'h1 << lowest_chan(mask_q)));
		out4 = (core.code[DATA_W-1:NIB_LO] > lim_hi_q[DATA_W-1:NIB_LO])
			|| (core.code[DATA_W-1:NIB_LO]
			< lim_lo_q[DATA_W-1:NIB_LO]);
		out8 = (core.code > lim_hi_q) || (core.code < lim_lo_q);
	end

	// ==========================================================
	// Sequencer next state
	always_comb
	begin
		st_d     = st_q;
		chan_d   = chan_q;
		slot_d   = slot_q;
		pend_d   = pend_q;
		early_d  = early_q;
		start_d  = 1'b0;
		res_we   = 1'b0;
		res_idx  = chan_q;
		set_done = 1'b0;
		set_bnd  = 1'b0;
		if (stop)
			st_d = ST_IDLE;
		else
		begin
			case (st_q)
				ST_IDLE, ST_WAIT:
				begin
					// Timer pulses only launch from rest
					if (go)
					begin
						// A step resumes its scan, anything else starts over
						if (st_q == ST_IDLE || go_mode != MODE_STEP)
						begin
							chan_d = lowest_chan(mask_q);
							pend_d = (go_mode == MODE_FIX_SINGLE
								|| go_mode == MODE_FIX_CONT
								|| go_mode == MODE_DUAL_CONT) ? 4'h0
								: mask_q & ~(4'h1 << lowest_chan(mask_q));
							slot_d = 2'h0;
						end
						start_d = 1'b1;
						st_d    = ST_CONV;
					end
				end
				ST_CONV:
				begin
					if (start_q)
						early_d = 1'b0;
					// Early nibble compare, then full compare
					if (core.nib_valid && bie_q && out4)
					begin
						set_bnd = 1'b1;
						early_d = 1'b1;
					end
					if (core.done)
					begin
						res_we  = 1'b1;
						set_bnd = bie_q && !early_q && out8;
						case (mode)
							MODE_FIX_CONT:
							begin
								// Same channel into slots 0..3
								res_idx  = slot_q;
								slot_d   = slot_q + 1'b1;
								set_done = (slot_q == LAST_SLOT);
								start_d  = 1'b1;
							end
							MODE_DUAL_CONT:
							begin
								// Alternate channels into slots 0..3
								res_idx  = slot_q;
								slot_d   = slot_q + 1'b1;
								chan_d   = slot_q[0] ? lowest_chan(mask_q)
									: chan_b;
								set_done = (slot_q == LAST_SLOT);
								start_d  = 1'b1;
							end
							MODE_SCAN_CONT:
							begin
								// Per-channel registers, endless passes
								start_d = 1'b1;
								if (pend_q == 4'h0)
								begin
									set_done = 1'b1;
									chan_d   = lowest_chan(mask_q);
									pend_d   = mask_q
										& ~(4'h1 << lowest_chan(mask_q));
								end
								else
								begin
									chan_d = lowest_chan(pend_q);
									pend_d = pend_q
										& ~(4'h1 << lowest_chan(pend_q));
								end
							end
							MODE_STEP:
							begin
								// One channel per start event
								set_done = 1'b1;
								st_d     = ST_WAIT;
								if (pend_q == 4'h0)
								begin
									chan_d = lowest_chan(mask_q);
									pend_d = mask_q
										& ~(4'h1 << lowest_chan(mask_q));
								end
								else
								begin
									chan_d = lowest_chan(pend_q);
									pend_d = pend_q
										& ~(4'h1 << lowest_chan(pend_q));
								end
							end
							default:
							begin
								// Fixed single and scan single
								if (pend_q == 4'h0)
								begin
									set_done = 1'b1;
									st_d     = ST_IDLE;
								end
								else
								begin
									chan_d  = lowest_chan(pend_q);
									pend_d  = pend_q
										& ~(4'h1 << lowest_chan(pend_q));
									start_d = 1'b1;
								end
							end
						endcase
					end
				end
				default:
					st_d = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			st_q    <= ST_IDLE;
			chan_q  <= 2'h0;
			slot_q  <= 2'h0;
			pend_q  <= 4'h0;
			early_q <= 1'b0;
			start_q <= 1'b0;
		end
		else
		begin
			st_q    <= st_d;
			chan_q  <= chan_d;
			slot_q  <= slot_d;
			pend_q  <= pend_d;
			early_q <= early_d;
			start_q <= start_d;
		end
	end

	// Core drive
	assign core.start    = start_q;
	assign core.abort    = stop;
	assign core.comp     = comp_in;
	assign core.div_sel  = div_q;
	assign core.dac_val  = wdata_in;
	assign core.dac_load = dac_q && wr_in && addr_in == OFS_RES3;

	// ==========================================================
	// Register file next state
	always_comb
	begin
		en_d     = en_q;
		tmr_d    = tmr_q;
		dac_d    = dac_q;
		mode_d   = mode_q;
		mask_d   = mask_q;
		div_d    = div_q;
		die_d    = die_q;
		bie_d    = bie_q;
		lim_hi_d = lim_hi_q;
		lim_lo_d = lim_lo_q;
		fdone_d  = fdone_q;
		fbnd_d   = fbnd_q;
		res_d    = res_q;
		if (wr_in)
		begin
			case (addr_in)
				OFS_CTRL:
				begin
					en_d   = wdata_in[CTRL_EN];
					mode_d = wdata_in[CTRL_MODE +: 3];
					tmr_d  = wdata_in[CTRL_TMR];
					dac_d  = wdata_in[CTRL_DAC];
				end
				OFS_CHAN:   mask_d   = wdata_in[NCHAN-1:0];
				OFS_CLKDIV: div_d    = wdata_in[DIV_W-1:0];
				OFS_INTEN:
				begin
					die_d = wdata_in[IE_DONE];
					bie_d = wdata_in[IE_BND];
				end
				OFS_LIM_HI: lim_hi_d = wdata_in;
				OFS_LIM_LO: lim_lo_d = wdata_in;
				OFS_STATUS:
				begin
					// Write one to clear
					if (wdata_in[ST_DONE])
						fdone_d = 1'b0;
					if (wdata_in[ST_BND])
						fbnd_d = 1'b0;
				end
				OFS_RES3:   res_d[LAST_SLOT] = wdata_in;
				default:    ;
			endcase
		end
		// Hardware events override a same-cycle clear
		if (set_done)
			fdone_d = 1'b1;
		if (set_bnd)
			fbnd_d = 1'b1;
		if (res_we)
			res_d[res_idx] = core.code;
		irq_d  = (fdone_d && die_d) || (fbnd_d && bie_d);
		wake_d = idle_in && fdone_d && die_d;
	end

	// Read data, valid the cycle after the strobe
	always_comb
	begin
		rdata_d = ZERO_BYTE;
		if (rd_in)
		begin
			case (addr_in)
				OFS_CTRL:   rdata_d = {1'b0, dac_q, 1'b0, tmr_q,
					mode_q, en_q};
				OFS_CHAN:   rdata_d = {4'h0, mask_q};
				OFS_CLKDIV: rdata_d = {5'h00, div_q};
				OFS_STATUS: rdata_d = {5'h00, st_q != ST_IDLE,
					fbnd_q, fdone_q};
				OFS_INTEN:  rdata_d = {6'h00, bie_q, die_q};
				OFS_LIM_HI: rdata_d = lim_hi_q;
				OFS_LIM_LO: rdata_d = lim_lo_q;
				default:
				begin
					if (addr_in[ADDR_W-1:2] == OFS_RES0[ADDR_W-1:2])
						rdata_d = res_q[addr_in[1:0]];
				end
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			en_q     <= 1'b0;
			tmr_q    <= 1'b0;
			dac_q    <= 1'b0;
			mode_q   <= 3'h0;
			mask_q   <= 4'h1;
			div_q    <= '0;
			die_q    <= 1'b0;
			bie_q    <= 1'b0;
			lim_hi_q <= LIM_HI_RST;
			lim_lo_q <= LIM_LO_RST;
			fdone_q  <= 1'b0;
			fbnd_q   <= 1'b0;
			rdata_q  <= ZERO_BYTE;
			irq_q    <= 1'b0;
			wake_q   <= 1'b0;
			for (int i = 0; i < NCHAN; i++)
				res_q[i] <= ZERO_BYTE;
		end
		else
		begin
			en_q     <= en_d;
			tmr_q    <= tmr_d;
			dac_q    <= dac_d;
			mode_q   <= mode_d;
			mask_q   <= mask_d;
			div_q    <= div_d;
			die_q    <= die_d;
			bie_q    <= bie_d;
			lim_hi_q <= lim_hi_d;
			lim_lo_q <= lim_lo_d;
			fdone_q  <= fdone_d;
			fbnd_q   <= fbnd_d;
			rdata_q  <= rdata_d;
			irq_q    <= irq_d;
			wake_q   <= wake_d;
			res_q    <= res_d;
		end
	end

	// ==========================================================
	// Bus, interrupt, wakeup and analog-side outputs
	assign rdata_out      = rdata_q;
	assign irq_out        = irq_q;
	assign wake_out       = wake_q;
	assign mux_sel_out    = chan_q;
	assign sample_out     = core.sampling;
	assign dac_code_out   = core.code;
	assign dac_pin_en_out = dac_q;
endmodule

// ==== sim/adc_analog_model.sv ====
// Behavioural analog inputs, sample-and-hold and comparator
`timescale 1ns/100ps
module adc_analog_model
(
	input  wire logic        clk_in,     // Clock
	input  wire logic [31:0] levels_in,  // Four input levels
	input  wire logic [1:0]  mux_sel_in, // Channel select
	input  wire logic        sample_in,  // Tracking
	input  wire logic [7:0]  code_in,    // Trial code
	output logic             comp_out    // Held level at or above code
);
	logic [7:0] held_q = 8'h00;
	// Track the chosen input while sampling, hold it otherwise
	always @(posedge clk_in)
		if (sample_in)
			held_q <= levels_in[{mux_sel_in, 3'h0} +: 8];
	// Comparator against the trial code
	assign comp_out = held_q >= code_in;
endmodule

// ==== sim/adc_scan_sequencer_sva.sv ====
// Port assertions for the converter scan sequencer
`timescale 1ns/100ps
module adc_scan_sequencer_sva
	import adc_seq_pkg::*;
(
	input wire logic                            clk_in,         // Clock
	input wire logic                            reset_in,       // Reset
	input wire logic [adc_seq_pkg::ADDR_W-1:0] addr_in,        // Address
	input wire logic [adc_seq_pkg::DATA_W-1:0] wdata_in,       // Data
	input wire logic                            wr_in,          // Write
	input wire logic                            rd_in,          // Read
	input wire logic [adc_seq_pkg::DATA_W-1:0] rdata_out,      // Read data
	input wire logic                            idle_in,        // Idle
	input wire logic                            power_down_in,  // Off
	input wire logic                            sample_out,     // Tracking
	input wire logic [adc_seq_pkg::DATA_W-1:0] dac_code_out,   // Code
	input wire logic                            dac_pin_en_out, // DAC pin
	input wire logic                            irq_out,        // Interrupt
	input wire logic                            wake_out        // Wakeup
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// ==========================================================
	// Bus, events and conversion timing
	a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
		else $error("read data outside its cycle");
	a_wake_idle: assert property (!idle_in |=> !wake_out)
		else $error("wake outside idle");
	a_wake_irq: assert property (wake_out |-> irq_out)
		else $error("wake without interrupt");
	a_pd_quiet: assert property (power_down_in[*3] |-> !sample_out)
		else $error("sampling in power-down");
	a_dac_pin: assert property (wr_in && addr_in == OFS_CTRL &&
		wdata_in[CTRL_DAC] |-> ##[1:2] dac_pin_en_out)
		else $error("DAC pin not enabled");
	a_first_trial: assert property ($fell(sample_out) &&
		!$past(power_down_in) && !$past(wr_in) && !$past(wr_in, 2)
		|-> dac_code_out == MSB_TRIAL)
		else $error("first trial code wrong");
	a_irq_off: assert property (wr_in && addr_in == OFS_INTEN &&
		wdata_in == 8'h00 ##1 !(wr_in && addr_in == OFS_INTEN) |=> !irq_out)
		else $error("interrupt with enables clear");
	a_go_start: assert property (wr_in && addr_in == OFS_CTRL &&
		wdata_in[CTRL_EN] && wdata_in[CTRL_GO] && !power_down_in &&
		!sample_out |-> ##[2:9] sample_out)
		else $error("immediate start did not sample");
endmodule
bind adc_scan_sequencer adc_scan_sequencer_sva u_sva (.clk_in(clk_in),
	.reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
	.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .idle_in(idle_in),
	.power_down_in(power_down_in), .sample_out(sample_out),
	.dac_code_out(dac_code_out), .dac_pin_en_out(dac_pin_en_out),
	.irq_out(irq_out), .wake_out(wake_out));

// ==== sim/adc_scan_sequencer_tb.sv ====
// Self-checking bench for the converter scan sequencer
`timescale 1ns/100ps
module adc_scan_sequencer_tb;
	import adc_seq_pkg::*;
	logic       clk_in = 1'b0, reset_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
	logic       timer_ovf_in = 1'b0, idle_in = 1'b0, power_down_in = 1'b0;
	logic [3:0] addr_in = 4'h0;
	logic [7:0] wdata_in = 8'h00, rdata_out, dac_code_out, rd_v;
	logic [1:0] mux_sel_out;
	logic       comp_in, sample_out, dac_pin_en_out, irq_out, wake_out;
	logic [7:0] lv [4];
	logic [7:0] seed = 8'h5F;
	logic [7:0] b_lv [5] = '{8'hF0, 8'h85, 8'h20, 8'h60, 8'hF0};
	logic [7:0] b_ie [5] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h01};
	logic [7:0] b_ex [5] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
	int         fail_count = 0, num_checks = 0, n, t0, cyc;
	wire [31:0] lv_bus = {lv[3], lv[2], lv[1], lv[0]};
	always #12.5 clk_in = ~clk_in;
	adc_scan_sequencer uut (.clk_in(clk_in), .reset_in(reset_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .timer_ovf_in(timer_ovf_in),
		.idle_in(idle_in), .power_down_in(power_down_in), .comp_in(comp_in),
		.mux_sel_out(mux_sel_out), .sample_out(sample_out),
		.dac_code_out(dac_code_out), .dac_pin_en_out(dac_pin_en_out),
		.irq_out(irq_out), .wake_out(wake_out));
	adc_analog_model u_model (.clk_in(clk_in), .levels_in(lv_bus),
		.mux_sel_in(mux_sel_out), .sample_in(sample_out),
		.code_in(dac_code_out), .comp_out(comp_in));
	// ==========================================================
	// Helpers
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [3:0] a);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		rd_v = rdata_out;
		@(posedge clk_in);
	endtask
	task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
		rd(a);
		chk(rd_v, e);
	endtask
	task automatic wait_flag();
		for (n = 0; n < 400; n++)
		begin
			rd(OFS_STATUS);
			if (rd_v[ST_DONE] === 1'b1)
				return;
		end
		fail_count++;
		$display("[ERR] %0t completion wait ran out", $time);
		end_sim();
	endtask
	task automatic new_levels();
		for (int i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			lv[i] <= seed;
		end
	endtask
	task automatic conv(input logic [7:0] ctrl, input logic [3:0] mask);
		wr(OFS_CHAN, {4'h0, mask});
		wr(OFS_STATUS, 8'h03);
		wr(OFS_CTRL, ctrl);
		wait_flag();
	endtask
	// Continuous run: two completions, then software stops it
	task automatic run_cont(input logic [7:0] ctrl, input logic [3:0] mask);
		conv(ctrl, mask);
		wr(OFS_STATUS, 8'h03);
		wait_flag();
		wr(OFS_CTRL, 8'h00);
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		new_levels();
		repeat (20) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		chk_rd(OFS_CHAN, 8'h01);
		chk_rd(OFS_LIM_HI, 8'hFF);
		chk_rd(OFS_STATUS, 8'h00);
		chk_rd(4'h7, 8'h00);
		wr(OFS_INTEN, 8'h01);
		conv(8'h21, 4'h4);
		chk_rd(OFS_RES0 + 4'h2, lv[2]);
		chk({7'h0, irq_out}, 8'h01);
		new_levels();
		conv(8'h25, 4'hB);
		for (int i = 0; i < 4; i++)
			if (i != 2)
				chk_rd(OFS_RES0 + 4'(i), lv[i]);
		chk_rd(OFS_STATUS, 8'h01);
		new_levels();
		conv(8'h3B, 4'h6);
		chk_rd(OFS_RES0 + 4'h1, lv[1]);
		chk_rd(OFS_STATUS, 8'h05);
		chk({6'h0, mux_sel_out}, 8'h02);
		wr(OFS_STATUS, 8'h03);
		timer_ovf_in <= 1'b1;
		@(posedge clk_in);
		timer_ovf_in <= 1'b0;
		// A late second start would convert channel 1 at a new level
		lv[1] <= ~lv[1];
		repeat (4) @(posedge clk_in);
		timer_ovf_in <= 1'b1;
		@(posedge clk_in);
		timer_ovf_in <= 1'b0;
		wait_flag();
		repeat (20) @(posedge clk_in);
		chk_rd(OFS_RES0 + 4'h2, lv[2]);
		chk_rd(OFS_STATUS, 8'h05);
		chk_rd(OFS_RES0 + 4'h1, ~lv[1]);
		for (int k = 0; k < 2; k++)
		begin
			new_levels();
			run_cont(8'h23, 4'h1);
			for (int i = 0; i < 4; i++)
				chk_rd(OFS_RES0 + 4'(i), lv[0]);
		end
		run_cont(8'h29, 4'h5);
		for (int i = 0; i < 4; i++)
			chk_rd(OFS_RES0 + 4'(i), lv[2 * (i % 2)]);
		new_levels();
		run_cont(8'h27, 4'hA);
		chk_rd(OFS_RES0 + 4'h1, lv[1]);
		chk_rd(OFS_RES0 + 4'h3, lv[3]);
		wr(OFS_LIM_HI, 8'h80);
		wr(OFS_LIM_LO, 8'h40);
		for (int i = 0; i < 5; i++)
		begin
			lv[0] <= b_lv[i];
			wr(OFS_INTEN, b_ie[i]);
			conv(8'h21, 4'h1);
			rd(OFS_STATUS);
			chk({7'h0, rd_v[ST_BND]}, b_ex[i]);
		end
		idle_in <= 1'b1;
		conv(8'h21, 4'h1);
		repeat (2) @(posedge clk_in);
		chk({7'h0, wake_out}, 8'h01);
		idle_in <= 1'b0;
		wr(OFS_INTEN, 8'h00);
		repeat (3) @(posedge clk_in);
		chk({7'h0, irq_out}, 8'h00);
		wr(OFS_STATUS, 8'h03);
		power_down_in <= 1'b1;
		wr(OFS_CTRL, 8'h21);
		repeat (30) @(posedge clk_in);
		chk_rd(OFS_STATUS, 8'h00);
		power_down_in <= 1'b0;
		wr(OFS_CTRL, 8'h40);
		wr(OFS_RES3, 8'h5A);
		repeat (3) @(posedge clk_in);
		chk(dac_code_out, 8'h5A);
		chk({7'h0, dac_pin_en_out}, 8'h01);
		chk_rd(OFS_RES3, 8'h5A);
		for (int d = 0; d < 8; d++)
		begin
			new_levels();
			wr(OFS_CLKDIV, 8'(d));
			wr(OFS_STATUS, 8'h03);
			t0 = $time;
			wr(OFS_CTRL, 8'h21);
			wait_flag();
			cyc = ($time - t0) / 25;
			chk(8'(cyc >= 8 * (d + 1) && cyc <= 9 * (d + 1) + 10), 8'h01);
			chk_rd(OFS_RES0, lv[0]);
		end
		end_sim();
	end
endmodule
